// ---- rtl/srx_ctrl.sv ----
// Deserializer control, configuration and status logic with Wishbone and serial control bus
`timescale 1ns/10ps
module srx_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Configuration pins
  input wire logic power_down_n,
  input wire logic parallel_output_enable,
  input wire logic sleep_state_select,
  input wire logic output_swing_select,
  input wire logic low_band_select,
  input wire logic lane_map_select,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] spread_range_select,
  input wire logic self_test_enable,
  input wire logic [3:0] bus_address_select,
  // Link side status
  input wire logic pll_locked,
  input wire logic self_test_error,
  input wire logic parallel_clock_lane,
  // Shared strap and pass pin
  input wire logic pass_pin_i,
  output logic pass_pin_o,
  output logic pass_pin_oe,
  // Serial control bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status and settings out
  output logic lock_o,
  output logic lock_oe,
  output logic parallel_drive_en,
  output logic parallel_quiet,
  output logic output_swing,
  output logic low_band_mode,
  output logic lane_map,
  output logic spread_clock_gen,
  output logic [2:0] spread_range,
  output logic common_filter_en,
  output logic [1:0] link_family,
  output logic equalizer_high_gain
);
  import srx_pkg::*;

  srx_state_t q;
  srx_state_t d;
  logic [`SRX_PIN_W-1:0] pins;
  logic pdn_s;
  logic pll_s;
  logic ste_s;
  logic err_s;
  logic oe_s;
  logic oss_s;
  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  logic freq_ok;

  assign pins = {bus_address_select, power_down_n, parallel_output_enable, sleep_state_select,
                 output_swing_select, low_band_select, lane_map_select, op_mode,
                 spread_range_select, self_test_enable, pll_locked, self_test_error,
                 pass_pin_i, scl_i, sda_i, parallel_clock_lane};

  // Only the second and third flops are read by logic
  assign pdn_s = q.s2[`SRX_PIN_PDN];
  assign pll_s = q.s2[`SRX_PIN_PLL];
  assign ste_s = q.s2[`SRX_PIN_STE];
  assign err_s = q.s2[`SRX_PIN_ERR];
  assign oe_s = q.s2[`SRX_PIN_OE];
  assign oss_s = q.s2[`SRX_PIN_OSS];
  assign scl_s = q.s2[`SRX_PIN_SCL];
  assign scl_p = q.s3[`SRX_PIN_SCL];
  assign sda_s = q.s2[`SRX_PIN_SDA];
  assign sda_p = q.s3[`SRX_PIN_SDA];

  // Sampling at 5 ns only resolves the period coarsely; limit is taken at whole cycles
  assign freq_ok = (q.per_last > 6'(`SRX_SSC_MIN_PER_CYC)) &&
                   (q.per_last <= 6'(`SRX_LINK_MAX_PER_CYC));

  function automatic logic [31:0] reg_rd(input logic [7:0] a, input srx_state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `SRX_REG_CTRL: r[7:0] = s.ctrl;
      `SRX_REG_STATUS: r[8:0] = {s.range, s.family, s.bist, s.eq, !s.err_seen, s.lock};
      `SRX_REG_IRQ_STAT: r[`SRX_IRQ_W-1:0] = s.stat;
      `SRX_REG_IRQ_MASK: r[`SRX_IRQ_W-1:0] = s.mask;
      `SRX_REG_ADDR: r[7:0] = {s.ssc_on, s.dev_addr};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : reg_rd

  function automatic srx_state_t reg_wr(input srx_state_t s, input logic [7:0] a,
                                        input logic [7:0] v);
    srx_state_t r;
    r = s;
    case (a)
      `SRX_REG_CTRL: r.ctrl = v;
      `SRX_REG_IRQ_MASK: r.mask = v[`SRX_IRQ_W-1:0];
      default: r = s;
    endcase
    return r;
  endfunction : reg_wr

  always_comb begin
    logic [31:0] w32;
    logic [`SRX_IRQ_W-1:0] ev;
    logic [`SRX_IRQ_W-1:0] clr;
    logic scl_r;
    logic scl_f;
    logic start;
    logic stop;
    logic [7:0] ridx;
    w32 = 32'h0000_0000;
    ev = '0;
    clr = '0;
    scl_r = scl_s & !scl_p;
    scl_f = !scl_s & scl_p;
    start = scl_s & scl_p & sda_p & !sda_s;
    stop = scl_s & scl_p & !sda_p & sda_s;
    ridx = 8'h00;
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Recovered pixel clock period, counted in mclk cycles between rising edges
    if (q.s2[`SRX_PIN_RXCLK] && !q.s3[`SRX_PIN_RXCLK]) begin
      d.per = 6'h01;
      d.per_last = q.per;
    end else if (q.per != 6'h3F) begin
      d.per = q.per + 6'h01;
    end else begin
      d.per_last = 6'h3F;
    end

    // Settings: register override wins for swing, low band and lane map, else the pin
    d.swing = q.ctrl[`SRX_CTRL_SWING_OV] ? q.ctrl[`SRX_CTRL_SWING]
                                         : q.s2[`SRX_PIN_SWING];
    d.lowb = q.ctrl[`SRX_CTRL_LOWB_OV] ? q.ctrl[`SRX_CTRL_LOWB]
                                       : q.s2[`SRX_PIN_LOWB];
    d.map = q.ctrl[`SRX_CTRL_MAP_OV] ? q.ctrl[`SRX_CTRL_MAP]
                                     : q.s2[`SRX_PIN_MAP];
    d.range = q.s2[`SRX_PIN_RANGE +: 3];
    d.family = q.s2[`SRX_PIN_MODE +: 2];
    d.filt = (q.s2[`SRX_PIN_MODE +: 2] == 2'h1);
    d.ssc_on = q.run && q.ctrl[`SRX_CTRL_SSC_EN] && (d.range != 3'h0) && freq_ok;

    // Lock and output state
    d.lock = q.run & pll_s;
    d.par_oe = q.run & oe_s & (pll_s | oss_s);
    d.par_quiet = q.run & oe_s & !pll_s & oss_s;

    // Self-test: error is sticky until self-test is left
    d.bist = q.run & ste_s;
    if (!q.bist) begin
      d.err_seen = 1'b0;
    end else if (err_s) begin
      d.err_seen = 1'b1;
    end

    ev[`SRX_IRQ_LOCK_UP] = !q.lock & d.lock;
    ev[`SRX_IRQ_LOCK_DN] = q.lock & !d.lock;
    ev[`SRX_IRQ_BIST_ERR] = q.bist & err_s & !q.err_seen;
    ev[`SRX_IRQ_SSC_OFF] = q.ssc_on & !d.ssc_on;

    // Serial control bus slave, open-drain data
    if (start) begin
      d.i2c = I2C_ADDR;
      d.cnt = 4'h0;
      d.have_idx = 1'b0;
      d.sda_drv = 1'b0;
    end else if (stop) begin
      d.i2c = I2C_IDLE;
      d.sda_drv = 1'b0;
    end else begin
      case (q.i2c)
        I2C_ADDR, I2C_WRITE: begin
          if (scl_r) begin
            d.sh = {q.sh[6:0], sda_s};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_f && q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            if (q.i2c == I2C_ADDR) begin
              if (q.sh[7:1] == q.dev_addr) begin
                d.rw = q.sh[0];
                d.sda_drv = 1'b1;
                d.i2c = I2C_ACKA;
              end else begin
                d.i2c = I2C_IDLE;
              end
            end else begin
              if (!q.have_idx) begin
                d.idx = q.sh;
                d.have_idx = 1'b1;
              end else begin
                d = reg_wr(d, {q.idx[5:0], 2'b00}, q.sh);
                d.idx = q.idx + 8'h01;
              end
              d.sda_drv = 1'b1;
              d.i2c = I2C_ACKW;
            end
          end
        end
        I2C_ACKA: begin
          if (scl_f) begin
            if (q.rw) begin
              w32 = reg_rd({q.idx[5:0], 2'b00}, q);
              d.rd = w32[7:0];
              d.sda_drv = !w32[7];
              d.i2c = I2C_READ;
            end else begin
              d.sda_drv = 1'b0;
              d.i2c = I2C_WRITE;
            end
          end
        end
        I2C_ACKW: begin
          if (scl_f) begin
            d.sda_drv = 1'b0;
            d.i2c = I2C_WRITE;
          end
        end
        I2C_READ: begin
          if (scl_r) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_f) begin
            if (q.cnt == 4'h8) begin
              d.cnt = 4'h0;
              d.sda_drv = 1'b0;
              d.i2c = I2C_RACK;
            end else begin
              d.rd = {q.rd[6:0], 1'b0};
              d.sda_drv = !q.rd[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_r) begin
            d.nack = sda_s;
          end else if (scl_f) begin
            if (q.nack) begin
              d.i2c = I2C_IDLE;
            end else begin
              ridx = q.idx + 8'h01;
              w32 = reg_rd({ridx[5:0], 2'b00}, q);
              d.idx = ridx;
              d.rd = w32[7:0];
              d.sda_drv = !w32[7];
              d.i2c = I2C_READ;
            end
          end
        end
        default: begin
          d.sda_drv = 1'b0;
          d.i2c = I2C_IDLE;
        end
      endcase
    end

    // Wishbone: one wait state, write lands on the edge that raises ack
    d.ack = wb_cyc_i & wb_stb_i & !q.ack;
    d.dat = 32'h0000_0000;
    if (d.ack) begin
      if (wb_we_i) begin
        if (wb_sel_i[0]) begin
          d = reg_wr(d, {wb_adr_i[7:2], 2'b00}, wb_dat_i[7:0]);
        end
      end else begin
        d.dat = reg_rd({wb_adr_i[7:2], 2'b00}, q);
        if ({wb_adr_i[7:2], 2'b00} == `SRX_REG_IRQ_STAT) begin
          clr = '1;
        end
      end
    end
    // New events survive a clearing read
    d.stat = (q.stat & ~clr) | ev;

    // Power-down clears run, drive enables, self-test, registers and serial bus; strap and address caught on release
    if (!pdn_s) begin
      d.run = 1'b0;
      // Drivers float in the first power-down cycle, not one later
      d.par_oe = 1'b0;
      d.par_quiet = 1'b0;
      d.bist = 1'b0;
      d.ctrl = `SRX_CTRL_RST;
      d.mask = `SRX_MASK_RST;
      d.stat = '0;
      d.err_seen = 1'b0;
      d.i2c = I2C_IDLE;
      d.sda_drv = 1'b0;
      d.have_idx = 1'b0;
    end else begin
      d.run = 1'b1;
      if (!q.run) begin
        d.eq = q.s2[`SRX_PIN_STRAP];
        d.dev_addr = `SRX_ID_BASE + {3'b000, q.s2[`SRX_PIN_ID +: 4]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= `SRX_CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign irq_o = |(q.stat & q.mask);
  assign lock_o = q.lock;
  assign lock_oe = q.run;
  assign parallel_drive_en = q.par_oe;
  assign parallel_quiet = q.par_quiet;
  assign output_swing = q.swing;
  assign low_band_mode = q.lowb;
  assign lane_map = q.map;
  assign spread_clock_gen = q.ssc_on;
  assign spread_range = q.range;
  assign common_filter_en = q.filt;
  assign link_family = q.family;
  assign equalizer_high_gain = q.eq;
  assign pass_pin_o = !q.err_seen;
  assign pass_pin_oe = q.bist;
  assign sda_o = 1'b0;
  assign sda_oe = q.sda_drv;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  lock_high_a: assert property (q.run && pll_s |=> lock_o)
    else $error("lock not raised while locked");
  lock_low_a: assert property (!pll_s && pdn_s |=> !lock_o &&
    parallel_quiet == $past(q.run && oe_s && oss_s) &&
    parallel_drive_en == $past(q.run && oe_s && oss_s))
    else $error("unlocked output state wrong");
  pd_float_a: assert property (!pdn_s |=> !parallel_drive_en && !lock_oe &&
    !pass_pin_oe && !sda_oe)
    else $error("outputs driven in power-down");
  pd_regs_a: assert property (!pdn_s |=> q.ctrl == `SRX_CTRL_RST &&
    q.mask == `SRX_MASK_RST && q.stat == '0)
    else $error("control registers not reset in power-down");
  swing_pin_a: assert property (!q.ctrl[`SRX_CTRL_SWING_OV] |=>
    output_swing == $past(q.s2[`SRX_PIN_SWING]))
    else $error("swing not following pin");
  map_reg_a: assert property (q.ctrl[`SRX_CTRL_MAP_OV] |=>
    lane_map == $past(q.ctrl[`SRX_CTRL_MAP]))
    else $error("lane map override ignored");
  ssc_fast_a: assert property (q.per_last <= 6'(`SRX_SSC_MIN_PER_CYC) |=>
    !spread_clock_gen)
    else $error("spread spectrum above limit");
  filter_mode_a: assert property (q.s2[`SRX_PIN_MODE +: 2] == 2'h1 |=>
    common_filter_en)
    else $error("filter not enabled in mode 01");
  pass_fail_a: assert property (q.bist && err_s |=> !pass_pin_o [*2] or !q.bist)
    else $error("pass not dropped after error");
  strap_hold_a: assert property (q.run && $past(q.run) |->
    $stable(equalizer_high_gain))
    else $error("equalizer strap changed while running");
endmodule : srx_ctrl

// ---- rtl/srx_map.svh ----
// Register offsets, bit positions, pin indices and timing counts of the receiver control block
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

// Wishbone byte addresses, one 32-bit word each
`define SRX_REG_CTRL 8'h00
`define SRX_REG_STATUS 8'h04
`define SRX_REG_IRQ_STAT 8'h08
`define SRX_REG_IRQ_MASK 8'h0C
`define SRX_REG_ADDR 8'h10

// Control register bits
`define SRX_CTRL_SWING_OV 0
`define SRX_CTRL_SWING 1
`define SRX_CTRL_LOWB_OV 2
`define SRX_CTRL_LOWB 3
`define SRX_CTRL_MAP_OV 4
`define SRX_CTRL_MAP 5
`define SRX_CTRL_SSC_EN 6
`define SRX_CTRL_RST 8'h40
`define SRX_MASK_RST 4'h0

// Interrupt status and mask bits
`define SRX_IRQ_LOCK_UP 0
`define SRX_IRQ_LOCK_DN 1
`define SRX_IRQ_BIST_ERR 2
`define SRX_IRQ_SSC_OFF 3
`define SRX_IRQ_W 4

// Positions in the synchronised pin vector
`define SRX_PIN_RXCLK 0
`define SRX_PIN_SDA 1
`define SRX_PIN_SCL 2
`define SRX_PIN_STRAP 3
`define SRX_PIN_ERR 4
`define SRX_PIN_PLL 5
`define SRX_PIN_STE 6
`define SRX_PIN_RANGE 7
`define SRX_PIN_MODE 10
`define SRX_PIN_MAP 12
`define SRX_PIN_LOWB 13
`define SRX_PIN_SWING 14
`define SRX_PIN_OSS 15
`define SRX_PIN_OE 16
`define SRX_PIN_PDN 17
`define SRX_PIN_ID 18
`define SRX_PIN_W 22

// Control bus address base; value is arbitrary, the strap code is added to it
`define SRX_ID_BASE 7'h30

// Timing: clock period and frequency limits of the recovered pixel clock
`define SRX_MCLK_PS 5000
`define SRX_SSC_MAX_KHZ 65000
`define SRX_LOWB_MIN_KHZ 10000
`define SRX_SSC_MIN_PER_CYC ((1000000000 / `SRX_SSC_MAX_KHZ) / `SRX_MCLK_PS)
`define SRX_LINK_MAX_PER_CYC ((1000000000 / `SRX_LOWB_MIN_KHZ) / `SRX_MCLK_PS)

`endif

// ---- rtl/srx_pkg.sv ----
// Types of the receiver control block
package srx_pkg;
`include "srx_map.svh"

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACKA, I2C_WRITE, I2C_ACKW, I2C_READ, I2C_RACK
  } srx_i2c_t;

  typedef struct packed {
    logic [`SRX_PIN_W-1:0] s1;
    logic [`SRX_PIN_W-1:0] s2;
    logic [`SRX_PIN_W-1:0] s3;
    logic run;
    logic lock;
    logic bist;
    logic err_seen;
    logic eq;
    logic ssc_on;
    logic swing;
    logic lowb;
    logic map;
    logic filt;
    logic par_oe;
    logic par_quiet;
    logic ack;
    logic sda_drv;
    logic have_idx;
    logic rw;
    logic nack;
    logic [1:0] family;
    logic [2:0] range;
    logic [6:0] dev_addr;
    logic [7:0] ctrl;
    logic [`SRX_IRQ_W-1:0] mask;
    logic [`SRX_IRQ_W-1:0] stat;
    logic [5:0] per;
    logic [5:0] per_last;
    srx_i2c_t i2c;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] idx;
    logic [7:0] rd;
    logic [31:0] dat;
  } srx_state_t;
endpackage : srx_pkg

// ---- verification/srx_far_model.sv ----
// Far-side model: link status and recovered pixel clock
`timescale 1ns/10ps
module srx_far_model (
  // Scenario controls
  input wire logic clk_run,
  input wire logic lock_req,
  input wire logic err_req,
  // Link status toward the block
  output logic pll_locked,
  output logic self_test_error,
  output logic parallel_clock_lane
);
  // Lock follows the scenario only, never glitches on its own
  assign pll_locked = lock_req;
  assign self_test_error = err_req;
  // 48 ns pixel clock; parks low when stopped so a dead link is visible
  initial begin
    parallel_clock_lane = 1'b0;
    forever begin
      #24;
      parallel_clock_lane = clk_run ? ~parallel_clock_lane : 1'b0;
    end
  end
endmodule : srx_far_model

// ---- verification/tb_srx_ctrl.sv ----
// Self-checking bench of the receiver control block
`timescale 1ns/10ps
`include "srx_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_srx_ctrl;
  import srx_pkg::*;
  logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic power_down_n, parallel_output_enable, sleep_state_select, output_swing_select;
  logic low_band_select, lane_map_select, self_test_enable, pll_locked, self_test_error;
  logic [1:0] op_mode, link_family;
  logic [2:0] spread_range_select, spread_range;
  logic [3:0] bus_address_select;
  logic parallel_clock_lane, pass_pin_i, pass_pin_o, pass_pin_oe, scl_i, sda_i, sda_o, sda_oe;
  logic lock_o, lock_oe, parallel_drive_en, parallel_quiet, output_swing, low_band_mode;
  logic lane_map, spread_clock_gen, common_filter_en, equalizer_high_gain;
  logic strap, clk_run, lock_req, err_req, sda_m;
  int n_fail = 0;
  int n_tests = 0;

  // Shared pin shows the strap only while the block does not drive it
  assign pass_pin_i = pass_pin_oe ? pass_pin_o : strap;
  // Open-drain data line: low if either side pulls, else the pull-up wins
  assign sda_i = ~(sda_oe | sda_m);

  srx_ctrl uut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .power_down_n, .parallel_output_enable,
    .sleep_state_select, .output_swing_select, .low_band_select, .lane_map_select, .op_mode,
    .spread_range_select, .self_test_enable, .bus_address_select, .pll_locked,
    .self_test_error, .parallel_clock_lane, .pass_pin_i, .pass_pin_o, .pass_pin_oe, .scl_i,
    .sda_i, .sda_o, .sda_oe, .lock_o, .lock_oe, .parallel_drive_en, .parallel_quiet,
    .output_swing, .low_band_mode, .lane_map, .spread_clock_gen, .spread_range,
    .common_filter_en, .link_family, .equalizer_high_gain);
  srx_far_model far (.clk_run, .lock_req, .err_req, .pll_locked, .self_test_error,
    .parallel_clock_lane);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task end_of_test;
    $display("Tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Pins pass a 2-flop synchroniser, so settle before looking
  task wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : wt

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Ack and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64) `CHK("wb_ack_o", 1'b1, wb_ack_o)
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task t_reset;
    wb(1'b0, `SRX_REG_CTRL, 32'h0, rd);
    `CHK("ctrl", 32'h40, rd)
    wb(1'b0, `SRX_REG_IRQ_MASK, 32'h0, rd);
    `CHK("mask", 32'h0, rd)
    wb(1'b0, 8'h1C, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b0, `SRX_REG_ADDR, 32'h0, rd);
    `CHK("dev_addr", `SRX_ID_BASE + 7'h05, rd[6:0])
    `CHK("eq_gain", 1'b1, equalizer_high_gain)
    $display("Test reset done");
  endtask : t_reset

  task t_pins;
    @(posedge mclk);
    output_swing_select <= 1'b1;
    low_band_select <= 1'b0;
    lane_map_select <= 1'b1;
    wt(5);
    `CHK("swing", 1'b1, output_swing)
    `CHK("low_band", 1'b0, low_band_mode)
    `CHK("lane_map", 1'b1, lane_map)
    wb(1'b1, `SRX_REG_CTRL, 32'h5D, rd);
    wt(2);
    `CHK("swing_ov", 1'b0, output_swing)
    `CHK("low_band_ov", 1'b1, low_band_mode)
    `CHK("lane_map_ov", 1'b0, lane_map)
    wb(1'b1, `SRX_REG_CTRL, 32'h40, rd);
    wt(2);
    `CHK("swing_pin", 1'b1, output_swing)
    $display("Test pins done");
  endtask : t_pins

  task t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      op_mode <= 2'(m);
      wt(5);
      `CHK("family", 2'(m), link_family)
      `CHK("filter", m == 1, common_filter_en)
    end
    $display("Test modes done");
  endtask : t_modes

  task t_lock;
    wb(1'b1, `SRX_REG_IRQ_MASK, 32'h1, rd);
    @(posedge mclk);
    parallel_output_enable <= 1'b1;
    sleep_state_select <= 1'b1;
    lock_req <= 1'b1;
    wt(5);
    `CHK("lock", 1'b1, lock_o)
    `CHK("drive", 1'b1, parallel_drive_en)
    `CHK("irq_up", 1'b1, irq_o)
    @(posedge mclk);
    parallel_output_enable <= 1'b0;
    wt(5);
    `CHK("drive_off", 1'b0, parallel_drive_en)
    wb(1'b0, `SRX_REG_IRQ_STAT, 32'h0, rd);
    `CHK("stat_up", 1'b1, rd[0])
    wt(2);
    `CHK("irq_clr", 1'b0, irq_o)
    @(posedge mclk);
    lock_req <= 1'b0;
    parallel_output_enable <= 1'b1;
    wt(5);
    `CHK("unlock", 1'b0, lock_o)
    `CHK("quiet", 1'b1, parallel_quiet)
    `CHK("drive_ul", 1'b1, parallel_drive_en)
    `CHK("irq_masked", 1'b0, irq_o)
    @(posedge mclk);
    sleep_state_select <= 1'b0;
    wt(5);
    `CHK("float", 1'b0, parallel_quiet)
    `CHK("float_drive", 1'b0, parallel_drive_en)
    wb(1'b0, `SRX_REG_IRQ_STAT, 32'h0, rd);
    `CHK("stat_dn", 2'b10, rd[1:0])
    $display("Test lock done");
  endtask : t_lock

  task t_bist;
    @(posedge mclk);
    self_test_enable <= 1'b1;
    wt(5);
    `CHK("pass_oe", 1'b1, pass_pin_oe)
    `CHK("pass", 1'b1, pass_pin_o)
    @(posedge mclk);
    err_req <= 1'b1;
    wt(5);
    @(posedge mclk);
    err_req <= 1'b0;
    wt(5);
    `CHK("fail_held", 1'b0, pass_pin_o)
    @(posedge mclk);
    self_test_enable <= 1'b0;
    wt(5);
    `CHK("pass_off", 1'b0, pass_pin_oe)
    $display("Test self-test done");
  endtask : t_bist

  task t_spread;
    @(posedge mclk);
    spread_range_select <= 3'h5;
    clk_run <= 1'b1;
    wt(100);
    `CHK("range", 3'h5, spread_range)
    `CHK("ssc_on", 1'b1, spread_clock_gen)
    wb(1'b1, `SRX_REG_CTRL, 32'h0, rd);
    wt(2);
    `CHK("ssc_off", 1'b0, spread_clock_gen)
    $display("Test spread done");
  endtask : t_spread

  task t_power;
    @(posedge mclk);
    lock_req <= 1'b1;
    wt(5);
    `CHK("drive_pre", 1'b1, parallel_drive_en)
    @(posedge mclk);
    power_down_n <= 1'b0;
    strap <= 1'b0;
    bus_address_select <= 4'h2;
    wt(5);
    `CHK("pd_lock", 1'b0, lock_oe)
    `CHK("pd_drive", 1'b0, parallel_drive_en)
    wb(1'b1, `SRX_REG_CTRL, 32'h1D, rd);
    @(posedge mclk);
    power_down_n <= 1'b1;
    wt(5);
    wb(1'b0, `SRX_REG_CTRL, 32'h0, rd);
    `CHK("ctrl_pd", 32'h40, rd)
    `CHK("eq_low", 1'b0, equalizer_high_gain)
    wb(1'b0, `SRX_REG_ADDR, 32'h0, rd);
    `CHK("addr_pd", `SRX_ID_BASE + 7'h02, rd[6:0])
    $display("Test power-down done");
  endtask : t_power

  // Serial bus master phase: 11 clocks each, so SCL period stays above 100 ns
  task i2c_drv(input logic scl, input logic sda_low);
    @(posedge mclk);
    scl_i <= scl;
    sda_m <= sda_low;
    repeat (10) @(posedge mclk);
  endtask : i2c_drv

  // Data changes only while SCL is low
  task i2c_bit(input logic b);
    i2c_drv(1'b0, sda_m);
    i2c_drv(1'b0, !b);
    i2c_drv(1'b1, !b);
  endtask : i2c_bit

  task i2c_start;
    i2c_drv(1'b1, 1'b0);
    i2c_drv(1'b1, 1'b1);
  endtask : i2c_start

  task i2c_stop;
    i2c_drv(1'b0, 1'b1);
    i2c_drv(1'b1, 1'b1);
    i2c_drv(1'b1, 1'b0);
  endtask : i2c_stop

  task i2c_wr(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(v[i]);
    i2c_bit(1'b1);
    ack = !sda_i;
  endtask : i2c_wr

  // Reads one byte and ends the read with a NACK
  task i2c_rd(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1);
      v[i] = sda_i;
    end
    i2c_bit(1'b1);
  endtask : i2c_rd

  task t_serial;
    logic ack;
    logic [7:0] v;
    i2c_start;
    i2c_wr({`SRX_ID_BASE + 7'h02, 1'b0}, ack);
    `CHK("i2c_addr_ack", 1'b1, ack)
    i2c_wr(8'h00, ack);
    `CHK("i2c_idx_ack", 1'b1, ack)
    i2c_wr(8'h15, ack);
    `CHK("i2c_data_ack", 1'b1, ack)
    i2c_stop;
    wb(1'b0, `SRX_REG_CTRL, 32'h0, rd);
    `CHK("i2c_ctrl", 32'h15, rd)
    `CHK("i2c_swing", 1'b0, output_swing)
    i2c_start;
    i2c_wr({`SRX_ID_BASE + 7'h02, 1'b0}, ack);
    i2c_wr(8'h00, ack);
    i2c_stop;
    i2c_start;
    i2c_wr({`SRX_ID_BASE + 7'h02, 1'b1}, ack);
    `CHK("i2c_rd_ack", 1'b1, ack)
    i2c_rd(v);
    `CHK("i2c_rd", 8'h15, v)
    i2c_stop;
    i2c_start;
    i2c_wr({`SRX_ID_BASE + 7'h03, 1'b0}, ack);
    `CHK("i2c_nack", 1'b0, ack)
    i2c_stop;
    `CHK("sda_o", 1'b0, sda_o)
    $display("Test serial bus done");
  endtask : t_serial

  initial begin
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    power_down_n = 1'b1;
    {parallel_output_enable, sleep_state_select, output_swing_select} = '0;
    {low_band_select, lane_map_select, self_test_enable, op_mode} = '0;
    spread_range_select = 3'h0;
    bus_address_select = 4'h5;
    scl_i = 1'b1;
    sda_m = 1'b0;
    {strap, clk_run, lock_req, err_req} = 4'h8;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_pins;
    t_modes;
    t_lock;
    t_bist;
    t_spread;
    t_power;
    t_serial;
    end_of_test;
  end

  // Whole run needs about 2900 cycles, the serial bus being the slow part
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_of_test;
  end
endmodule : tb_srx_ctrl
